/* File: src/svtc_cfg.svh */
// Constants for the serial voltage-ID target control block.
// Definitions only; included by the slew and top modules.
// Contract
// - Codes above the maximum-code register are refused as not supported; reset FBh.
// - The programmed voltage code register is read/write, default zero.
// - The power state register is read/write, default zero.
// - The margin offset, in code steps, is added to the programmed code.
// - The offset is 8-bit two's complement; FFh one step down.
// - Power states 0 and 1 force continuous conduction.
// - Power states 2 and 3 select automatic conduction with light-load pulse mode.
// - Power state 4 drives the target to zero; only the bus stays active.
// - Command 01h is a fast move at the fast rate; 02h a slow move.
// - Slow rate is the fast rate over 2, 4, 8 or 16; default selector 02h.
// - Command 03h is a decay move downward with no controlled slew.
// - Boot choice and bus address are captured once at power-up, then fixed.
// - Strap selects 0.9 V or 1.35 V and one of nine addresses.
// - After reaching boot voltage it holds until a voltage-set command arrives.
// - Bus clock is at most 43 MHz; the device works at any rate up to that.
// - Three open-drain wires: bus clock, bidirectional data, active-low alert.
`ifndef SVTC_CFG_SVH
`define SVTC_CFG_SVH
// Register indices
`define SVTC_IDX_SR_FAST 8'h24
`define SVTC_IDX_SR_SLOW 8'h25
`define SVTC_IDX_VBOOT 8'h26
`define SVTC_IDX_SR_SEL 8'h2A
`define SVTC_IDX_VMAX 8'h30
`define SVTC_IDX_VID 8'h31
`define SVTC_IDX_PS 8'h32
`define SVTC_IDX_OFFSET 8'h33
`define SVTC_IDX_MVR 8'h34
// Reset values
`define SVTC_RST_VMAX 8'hFB
`define SVTC_RST_VID 8'h00
`define SVTC_RST_PS 8'h00
`define SVTC_RST_OFFSET 8'h00
`define SVTC_RST_MVR 8'h00
`define SVTC_RST_SR_SEL 8'h02
`define SVTC_RST_VBOOT 8'h00
// Command codes
`define SVTC_CMD_FAST 5'h01
`define SVTC_CMD_SLOW 5'h02
`define SVTC_CMD_DECAY 5'h03
`define SVTC_CMD_SETPS 5'h04
`define SVTC_CMD_GETREG 5'h05
`define SVTC_CMD_SETREG 5'h06
// Acknowledge codes
`define SVTC_ACK_OK 2'h2
`define SVTC_ACK_NSUP 2'h1
`define SVTC_ACK_REJ 2'h3
// Power states and code limits
`define SVTC_PS_LOW 8'h01
`define SVTC_PS_ULTRA 8'h03
`define SVTC_PS_OFF 8'h04
`define SVTC_CODE_ZERO 8'h00
`define SVTC_CODE_TOP 8'hFF
`define SVTC_ADDR_TOP 4'h8
// Frame layout
`define SVTC_FRAME_LAST 5'h18
`define SVTC_TX_ACK_BITS 4'h2
`define SVTC_TX_READ_BITS 4'hA
// Slow selector limits
`define SVTC_SEL_MIN 8'h01
`define SVTC_SEL_MAX 8'h04
// Boot codes, plain defaults
`define SVTC_BOOT_LO_CODE 8'h83
`define SVTC_BOOT_HI_CODE 8'hDD
// Timing
`define SVTC_CLK_MHZ 100
`define SVTC_STEP_UV 5000
`define SVTC_SR_FAST_MV_US 14
`define SVTC_RST_SR_FAST 8'(`SVTC_SR_FAST_MV_US)
`define SVTC_FAST_STEP_CYC \
  ((`SVTC_STEP_UV * `SVTC_CLK_MHZ) / (`SVTC_SR_FAST_MV_US * 1000))
`define SVTC_STRAP_SETTLE_NS 1000
`define SVTC_STRAP_SETTLE_CYC ((`SVTC_STRAP_SETTLE_NS * `SVTC_CLK_MHZ + 999) / 1000)
`define SVTC_BUS_MAX_MHZ 43
`endif

/* File: src/svtc_pkg.sv */
// Types shared by the voltage-ID target control modules.
// Assumes svtc_cfg.svh for widths of nothing; types only.
package svtc_pkg;
  // Link-side frame states
  typedef enum logic [1:0] {
    SVTC_L_IDLE  = 2'b00,
    SVTC_L_SHIFT = 2'b01,
    SVTC_L_WAIT  = 2'b10,
    SVTC_L_TX    = 2'b11
  } svtc_link_state_t;
  // Rate of the last accepted move
  typedef enum logic [1:0] {
    SVTC_R_FAST  = 2'b00,
    SVTC_R_SLOW  = 2'b01,
    SVTC_R_DECAY = 2'b10
  } svtc_rate_t;
  // Request as shifted in from the bus
  typedef struct packed {
    logic [3:0] addr;
    logic [4:0] cmd;
    logic [7:0] idx;
    logic [7:0] data;
  } svtc_req_t;
  // Answer from the core domain
  typedef struct packed {
    logic       mine;
    logic       rd;
    logic [1:0] ack;
    logic [7:0] rdata;
  } svtc_rsp_t;
endpackage : svtc_pkg

/* File: src/svtc_sync.sv */
// Two-flop synchroniser for levels and toggles.
// Assumes the input is stable long enough to be seen twice.
`timescale 1ns/1ps
`default_nettype none
module svtc_sync import svtc_pkg::*; #(
  parameter int W = 1
) (
  // Destination domain
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : svtc_sync
`default_nettype wire

/* File: src/svtc_slew.sv */
// Stepping engine: moves the output code toward the target.
// Assumes target and rate come from the same core clock.
`timescale 1ns/1ps
`include "svtc_cfg.svh"
`default_nettype none
module svtc_slew import svtc_pkg::*; (
  // Core clock
  input  wire logic       clk,
  input  wire logic       rst,
  // Target and rate
  input  wire logic [7:0] target,
  input  wire svtc_rate_t rate,
  input  wire logic [2:0] slow_shift,
  // Output code and completion
  output logic      [7:0] code,
  output logic            done
);
  logic [11:0] cnt_reg;
  logic        busy_reg;

  // Step period per rate; slow is a power-of-two multiple
  wire [11:0] fast_cyc = 12'(`SVTC_FAST_STEP_CYC);
  wire [11:0] step_cyc = (rate == SVTC_R_SLOW) ? (fast_cyc << slow_shift) : fast_cyc;
  wire        at_tgt   = (code == target);
  wire        up       = (target > code);
  wire        jump     = (rate == SVTC_R_DECAY) && !up;
  wire        tick     = (cnt_reg >= step_cyc - 12'h001);

  // One code step per period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code    <= `SVTC_CODE_ZERO;
      cnt_reg <= 12'h000;
    end else if (at_tgt || jump) begin
      code    <= target;
      cnt_reg <= 12'h000;
    end else if (tick) begin
      code    <= up ? code + 8'h01 : code - 8'h01;
      cnt_reg <= 12'h000;
    end else begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  // Done pulses once when a move lands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else begin
      busy_reg <= !at_tgt;
      done     <= busy_reg && at_tgt;
    end
  end
endmodule : svtc_slew
`default_nettype wire

/* File: src/svtc_top.sv */
// Serial voltage-ID target control: bus link, registers and moves.
// Assumes rst follows the enable pin, bus_clk comes from the master,
// and the pads resolve the open-drain wires from the enables.
`timescale 1ns/1ps
`include "svtc_cfg.svh"
`default_nettype none
module svtc_top import svtc_pkg::*; (
  // Core clock and enable-driven reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Serial bus, open drain
  input  wire logic       bus_clk,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  output logic            alert_n_out,
  output logic            alert_n_oe,
  // Boot strap levels
  input  wire logic       strap_boot_hi,
  input  wire logic [3:0] strap_addr,
  // Power stage controls
  output logic      [7:0] dac_code,
  output logic            continuous_conduction,
  output logic            auto_conduction,
  output logic            output_off_state,
  output logic            vid_settled,
  output logic            strap_done
);

  ////////////////////////////////////////////////////////////////
  // Register decode helpers
  ////////////////////////////////////////////////////////////////

  // Indices that answer a read
  function automatic logic reg_readable(input logic [7:0] i);
    case (i)
      `SVTC_IDX_SR_FAST, `SVTC_IDX_SR_SLOW, `SVTC_IDX_VBOOT,
      `SVTC_IDX_SR_SEL, `SVTC_IDX_VMAX, `SVTC_IDX_VID,
      `SVTC_IDX_PS, `SVTC_IDX_OFFSET, `SVTC_IDX_MVR: reg_readable = 1'b1;
      default: reg_readable = 1'b0;
    endcase
  endfunction : reg_readable

  // Indices that take a write
  function automatic logic reg_writable(input logic [7:0] i);
    case (i)
      `SVTC_IDX_SR_SEL, `SVTC_IDX_VMAX, `SVTC_IDX_VID,
      `SVTC_IDX_PS, `SVTC_IDX_OFFSET, `SVTC_IDX_MVR: reg_writable = 1'b1;
      default: reg_writable = 1'b0;
    endcase
  endfunction : reg_writable

  ////////////////////////////////////////////////////////////////
  // Link domain: frames on the bus clock
  ////////////////////////////////////////////////////////////////

  svtc_link_state_t lst_reg;
  svtc_link_state_t lst_next;
  logic [23:0]      lsr_reg;
  logic [4:0]       lcnt_reg;
  svtc_req_t        lreq_reg;
  logic             lreq_tog_reg;
  logic             lrsp_seen_reg;
  logic [9:0]       ltx_reg;
  logic [3:0]       ltx_cnt_reg;
  logic             ldrive_reg;
  logic             lrsp_tog_s;
  svtc_rsp_t        crsp_reg;
  logic             crsp_tog_reg;

  // Answer toggle into the bus clock
  svtc_sync #(.W(1)) u_rsp_sync (
    .clk (bus_clk),
    .rst (rst),
    .d   (crsp_tog_reg),
    .q   (lrsp_tog_s)
  );

  // Frame events
  wire l_start   = (lst_reg == SVTC_L_IDLE) && !sdio_in;
  wire l_last    = (lst_reg == SVTC_L_SHIFT) && (lcnt_reg == `SVTC_FRAME_LAST);
  wire l_rsp     = (lst_reg == SVTC_L_WAIT) && (lrsp_tog_s != lrsp_seen_reg);
  wire l_tx_end  = (lst_reg == SVTC_L_TX) && (ltx_cnt_reg == 4'h0);
  wire l_rd_ok   = crsp_reg.rd && (crsp_reg.ack == `SVTC_ACK_OK);
  wire [3:0] l_tx_len = l_rd_ok ? `SVTC_TX_READ_BITS : `SVTC_TX_ACK_BITS;

  // Next link state; every step is one bus clock edge
  always_comb begin
    lst_next = lst_reg;
    case (lst_reg)
      SVTC_L_IDLE:  if (l_start) lst_next = SVTC_L_SHIFT;
      SVTC_L_SHIFT: if (l_last) lst_next = SVTC_L_WAIT;
      SVTC_L_WAIT:  if (l_rsp) lst_next = crsp_reg.mine ? SVTC_L_TX : SVTC_L_IDLE;
      SVTC_L_TX:    if (l_tx_end) lst_next = SVTC_L_IDLE;
      default:      lst_next = SVTC_L_IDLE;
    endcase
  end

  // State and bit counter; single-edge logic keeps 43 MHz timing easy
  always_ff @(posedge bus_clk or posedge rst) begin
    if (rst) begin
      lst_reg  <= SVTC_L_IDLE;
      lcnt_reg <= 5'h00;
    end else begin
      lst_reg  <= lst_next;
      lcnt_reg <= (lst_reg == SVTC_L_SHIFT) ? lcnt_reg + 5'h01 : 5'h00;
    end
  end

  // Shift in, then hold the request for the core to read
  always_ff @(posedge bus_clk or posedge rst) begin
    if (rst) begin
      lsr_reg      <= 24'h000000;
      lreq_reg     <= '0;
      lreq_tog_reg <= 1'b0;
    end else if (lst_reg == SVTC_L_SHIFT) begin
      lsr_reg <= {lsr_reg[22:0], sdio_in};
      if (l_last) begin
        lreq_reg     <= {lsr_reg, sdio_in};
        lreq_tog_reg <= !lreq_tog_reg;
      end
    end
  end

  // Answer shifted out MSB first; a zero pulls the wire low
  always_ff @(posedge bus_clk or posedge rst) begin
    if (rst) begin
      lrsp_seen_reg <= 1'b0;
      ltx_reg       <= 10'h000;
      ltx_cnt_reg   <= 4'h0;
      ldrive_reg    <= 1'b0;
    end else if (l_rsp) begin
      lrsp_seen_reg <= lrsp_tog_s;
      ltx_reg       <= {crsp_reg.ack, crsp_reg.rdata};
      ltx_cnt_reg   <= l_tx_len;
    end else if ((lst_reg == SVTC_L_TX) && !l_tx_end) begin
      ldrive_reg  <= !ltx_reg[9];
      ltx_reg     <= {ltx_reg[8:0], 1'b0};
      ltx_cnt_reg <= ltx_cnt_reg - 4'h1;
    end else begin
      ldrive_reg <= 1'b0;
    end
  end

  // Open-drain data: drive low only
  assign sdio_out = 1'b0;
  assign sdio_oe  = ldrive_reg;

  ////////////////////////////////////////////////////////////////
  // Core domain: strap capture
  ////////////////////////////////////////////////////////////////

  logic [4:0]  strap_s;
  logic [11:0] settle_reg;
  logic        strap_done_reg;
  logic [3:0]  addr_reg;
  logic [7:0]  boot_code_reg;

  // Strap pins are asynchronous levels
  svtc_sync #(.W(5)) u_strap_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({strap_boot_hi, strap_addr}),
    .q   (strap_s)
  );

  wire settle_end = (settle_reg == 12'(`SVTC_STRAP_SETTLE_CYC));
  // Addresses above the top band read as the top one
  wire [3:0] strap_addr_c = (strap_s[3:0] > `SVTC_ADDR_TOP) ? `SVTC_ADDR_TOP : strap_s[3:0];

  // Capture once after the strap settles; nothing rewrites it later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_reg     <= 12'h000;
      strap_done_reg <= 1'b0;
      addr_reg       <= 4'h0;
      boot_code_reg  <= `SVTC_CODE_ZERO;
    end else if (!strap_done_reg) begin
      settle_reg <= settle_reg + 12'h001;
      if (settle_end) begin
        strap_done_reg <= 1'b1;
        addr_reg       <= strap_addr_c;
        boot_code_reg  <= strap_s[4] ? `SVTC_BOOT_HI_CODE : `SVTC_BOOT_LO_CODE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Core domain: request decode
  ////////////////////////////////////////////////////////////////

  logic       creq_tog_s;
  logic       creq_seen_reg;
  logic [7:0] vmax_reg;
  logic [7:0] vid_reg;
  logic [7:0] ps_reg;
  logic [7:0] offset_reg;
  logic [7:0] mvr_reg;
  logic [7:0] sr_sel_reg;
  logic       boot_hold_reg;
  logic       alert_reg;
  svtc_rate_t rate_reg;
  logic [1:0] ack_c;
  logic [7:0] rdata_c;

  // Request toggle into the core clock
  svtc_sync #(.W(1)) u_req_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   (lreq_tog_reg),
    .q   (creq_tog_s)
  );

  // Request fields are stable once the toggle is seen
  wire       c_new   = (creq_tog_s != creq_seen_reg);
  wire       c_mine  = strap_done_reg && (lreq_reg.addr == addr_reg);
  wire       c_act   = c_new && c_mine;
  wire [4:0] c_cmd   = lreq_reg.cmd;
  wire [7:0] c_idx   = lreq_reg.idx;
  wire [7:0] c_data  = lreq_reg.data;
  wire       c_vcmd  = (c_cmd == `SVTC_CMD_FAST) || (c_cmd == `SVTC_CMD_SLOW) ||
                       (c_cmd == `SVTC_CMD_DECAY);
  wire       c_setr  = (c_cmd == `SVTC_CMD_SETREG);
  wire       c_code_ok = (c_data <= vmax_reg);
  wire       c_ps_ok = (c_data <= `SVTC_PS_OFF);
  wire       c_val_ok = ((c_idx != `SVTC_IDX_VID) || c_code_ok) &&
                        ((c_idx != `SVTC_IDX_PS) || c_ps_ok);
  wire       c_ok    = (ack_c == `SVTC_ACK_OK);

  // Acknowledge by command; a refused code leaves the software-visible registers, rate and boot hold as is
  always_comb begin
    ack_c = `SVTC_ACK_REJ;
    case (c_cmd)
      `SVTC_CMD_FAST, `SVTC_CMD_SLOW, `SVTC_CMD_DECAY:
        ack_c = c_code_ok ? `SVTC_ACK_OK : `SVTC_ACK_NSUP;
      `SVTC_CMD_SETPS:
        ack_c = c_ps_ok ? `SVTC_ACK_OK : `SVTC_ACK_NSUP;
      `SVTC_CMD_GETREG:
        ack_c = reg_readable(c_idx) ? `SVTC_ACK_OK : `SVTC_ACK_NSUP;
      `SVTC_CMD_SETREG:
        ack_c = (reg_writable(c_idx) && c_val_ok) ? `SVTC_ACK_OK : `SVTC_ACK_NSUP;
      default:
        ack_c = `SVTC_ACK_REJ;
    endcase
  end

  // Write strobes
  wire w_go   = c_act && c_ok;
  wire w_vid  = w_go && (c_vcmd || (c_setr && (c_idx == `SVTC_IDX_VID)));
  wire w_ps   = w_go && ((c_cmd == `SVTC_CMD_SETPS) || (c_setr && (c_idx == `SVTC_IDX_PS)));
  wire w_vmax = w_go && c_setr && (c_idx == `SVTC_IDX_VMAX);
  wire w_off  = w_go && c_setr && (c_idx == `SVTC_IDX_OFFSET);
  wire w_mvr  = w_go && c_setr && (c_idx == `SVTC_IDX_MVR);
  wire w_sel  = w_go && c_setr && (c_idx == `SVTC_IDX_SR_SEL);

  ////////////////////////////////////////////////////////////////
  // Core domain: registers
  ////////////////////////////////////////////////////////////////

  // Software-visible registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vmax_reg   <= `SVTC_RST_VMAX;
      vid_reg    <= `SVTC_RST_VID;
      ps_reg     <= `SVTC_RST_PS;
      offset_reg <= `SVTC_RST_OFFSET;
      mvr_reg    <= `SVTC_RST_MVR;
      sr_sel_reg <= `SVTC_RST_SR_SEL;
    end else begin
      if (w_vmax) vmax_reg <= c_data;
      if (w_vid) vid_reg <= c_data;
      if (w_ps) ps_reg <= c_data;
      if (w_off) offset_reg <= c_data;
      if (w_mvr) mvr_reg <= c_data;
      if (w_sel) sr_sel_reg <= c_data;
    end
  end

  // Move rate and boot hold follow voltage-set commands only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_reg      <= SVTC_R_FAST;
      boot_hold_reg <= 1'b1;
    end else if (w_go && c_vcmd) begin
      boot_hold_reg <= 1'b0;
      case (c_cmd)
        `SVTC_CMD_SLOW:  rate_reg <= SVTC_R_SLOW;
        `SVTC_CMD_DECAY: rate_reg <= SVTC_R_DECAY;
        default:         rate_reg <= SVTC_R_FAST;
      endcase
    end
  end

  // Slow selector: out-of-range values fall back to divide by four
  wire       sel_in  = (sr_sel_reg >= `SVTC_SEL_MIN) && (sr_sel_reg <= `SVTC_SEL_MAX);
  wire [7:0] sel_eff = sel_in ? sr_sel_reg : `SVTC_RST_SR_SEL;
  wire [2:0] slow_shift = sel_eff[2:0];
  wire [7:0] sr_slow = `SVTC_RST_SR_FAST >> slow_shift;

  // Read data mux
  always_comb begin
    rdata_c = `SVTC_CODE_ZERO;
    case (c_idx)
      `SVTC_IDX_SR_FAST: rdata_c = `SVTC_RST_SR_FAST;
      `SVTC_IDX_SR_SLOW: rdata_c = sr_slow;
      `SVTC_IDX_VBOOT:   rdata_c = `SVTC_RST_VBOOT;
      `SVTC_IDX_SR_SEL:  rdata_c = sr_sel_reg;
      `SVTC_IDX_VMAX:    rdata_c = vmax_reg;
      `SVTC_IDX_VID:     rdata_c = vid_reg;
      `SVTC_IDX_PS:      rdata_c = ps_reg;
      `SVTC_IDX_OFFSET:  rdata_c = offset_reg;
      `SVTC_IDX_MVR:     rdata_c = mvr_reg;
      default:           rdata_c = `SVTC_CODE_ZERO;
    endcase
  end

  // Answer held steady for the link to read after the toggle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      creq_seen_reg <= 1'b0;
      crsp_reg      <= '0;
      crsp_tog_reg  <= 1'b0;
    end else if (c_new) begin
      creq_seen_reg  <= creq_tog_s;
      crsp_reg.mine  <= c_mine;
      crsp_reg.rd    <= (c_cmd == `SVTC_CMD_GETREG);
      crsp_reg.ack   <= ack_c;
      crsp_reg.rdata <= rdata_c;
      crsp_tog_reg   <= !crsp_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Core domain: target forming and stepping
  ////////////////////////////////////////////////////////////////

  logic       slew_done;
  logic [7:0] slew_code;

  // Boot code until the first voltage-set, then the programmed code
  wire [7:0] base_code = boot_hold_reg ? boot_code_reg : vid_reg;
  // Sign-extended margin; top bit set lowers the code
  wire [9:0] margin_sum = {2'b00, base_code} + {{2{offset_reg[7]}}, offset_reg};
  wire [7:0] margined = margin_sum[9] ? `SVTC_CODE_ZERO :
                        (margin_sum[8] ? `SVTC_CODE_TOP : margin_sum[7:0]);
  wire       ps_off = (ps_reg == `SVTC_PS_OFF);
  wire [7:0] target_code = ps_off ? `SVTC_CODE_ZERO : margined;

  svtc_slew u_slew (
    .clk        (ref_clk),
    .rst        (rst),
    .target     (target_code),
    .rate       (rate_reg),
    .slow_shift (slow_shift),
    .code       (slew_code),
    .done       (slew_done)
  );

  // Alert on a finished move; the set wins over a same-cycle clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alert_reg <= 1'b0;
    end else if (slew_done) begin
      alert_reg <= 1'b1;
    end else if (c_act) begin
      alert_reg <= 1'b0;
    end
  end

  // Conduction mode from power state, registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      continuous_conduction <= 1'b1;
      auto_conduction       <= 1'b0;
      output_off_state      <= 1'b0;
      vid_settled           <= 1'b0;
    end else begin
      continuous_conduction <= (ps_reg <= `SVTC_PS_LOW);
      auto_conduction       <= (ps_reg > `SVTC_PS_LOW) && (ps_reg <= `SVTC_PS_ULTRA);
      output_off_state      <= ps_off;
      vid_settled           <= strap_done_reg && (slew_code == target_code);
    end
  end

  // Outputs
  assign dac_code    = slew_code;
  assign strap_done  = strap_done_reg;
  assign alert_n_out = 1'b0;
  assign alert_n_oe  = alert_reg;

endmodule : svtc_top
`default_nettype wire

/* File: bench/svtc_monitor.sv */
// Checker for the outputs of svtc_top.
// Assumes the core clock domain only; bound below.
`timescale 1ns/1ps
`default_nettype none
module svtc_monitor import svtc_pkg::*; (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Watched outputs
  input wire logic       sdio_out,
  input wire logic       alert_n_out,
  input wire logic [7:0] dac_code,
  input wire logic       continuous_conduction,
  input wire logic       auto_conduction,
  input wire logic       output_off_state,
  input wire logic       vid_settled,
  input wire logic       strap_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [9:0] cyc_reg;
  // Cycles since reset release, saturating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cyc_reg <= 10'h000;
    else if (cyc_reg != 10'h3FF) cyc_reg <= cyc_reg + 10'h001;
  end
  sequence s_rise;
    dac_code > $past(dac_code);
  endsequence
  AST_PINS: assert property (sdio_out == 1'b0 && alert_n_out == 1'b0)
    else $error("pin driven high");
  AST_CCM: assert property (continuous_conduction |-> !auto_conduction && !output_off_state)
    else $error("mode overlap ccm");
  AST_AUTO: assert property (auto_conduction |-> !continuous_conduction && !output_off_state)
    else $error("mode overlap auto");
  AST_OFF: assert property (output_off_state && $past(output_off_state) |-> dac_code <= $past(dac_code))
    else $error("code rose while off");
  AST_STEP: assert property (s_rise |-> dac_code == $past(dac_code) + 8'h01)
    else $error("rise not one step");
  AST_GAP: assert property (s_rise |=> $stable(dac_code) [*8])
    else $error("steps too close");
  AST_BOOT: assert property (!strap_done |-> dac_code == 8'h00)
    else $error("ramp before strap");
  AST_HOLD: assert property (strap_done |=> strap_done)
    else $error("strap done dropped");
  AST_SETTLE: assert property (vid_settled |-> strap_done)
    else $error("settled before strap");
  AST_STRAP: assert property ($rose(strap_done) |-> cyc_reg >= 10'h05F && cyc_reg <= 10'h06E)
    else $error("strap capture time");
endmodule : svtc_monitor
bind svtc_top svtc_monitor i_mon (.ref_clk, .rst, .sdio_out, .alert_n_out, .dac_code,
  .continuous_conduction, .auto_conduction, .output_off_state, .vid_settled, .strap_done);
`default_nettype wire

/* File: bench/svtc_master.sv */
// Bus master model: clocks one frame and samples the answer.
// Assumes the wire is resolved outside with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module svtc_master import svtc_pkg::*; (
  // Bus wires
  output logic      bus_clk,
  output logic      mst_oe,
  input  wire logic sdio
);
  logic [0:39] ans;
  initial begin
    bus_clk = 1'b0;
    mst_oe  = 1'b0;
  end
  // 80 ns period, clock still between frames; only pulls low
  task automatic frame(input svtc_req_t req, output logic found, output logic [7:0] rd);
    // Odd lead-in lets the bus phase drift against ref_clk
    #3;
    mst_oe = 1'b1;
    for (int k = 0; k < 66; k++) begin
      #40;
      if (k > 25) ans[k-26] = sdio;
      bus_clk = 1'b1;
      #1;
      mst_oe = (k < 25) ? !req[24-k] : 1'b0;
      #39;
      bus_clk = 1'b0;
    end
    // First low bit marks the ack; data follows it
    found = 1'b0;
    rd = 8'h00;
    for (int i = 0; i < 31; i++) begin
      if (!found && ans[i] === 1'b0) begin
        found = 1'b1;
        for (int j = 1; j <= 8; j++) rd = {rd[6:0], ans[i+j]};
      end
    end
  endtask : frame
endmodule : svtc_master
`default_nettype wire

/* File: bench/tb.sv */
// Testbench for svtc_top: register and move sequences over the bus.
// Assumes svtc_master as bus master and a pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import svtc_pkg::*;
  logic       ref_clk, rst, bus_clk, mst_oe, strap_boot_hi, found;
  logic       sdio_out, sdio_oe, alert_n_out, alert_n_oe, strap_done, vid_settled;
  logic       continuous_conduction, auto_conduction, output_off_state;
  logic [3:0] strap_addr;
  logic [7:0] dac_code, rd;
  wire logic  sdio;
  int         bad_count = 0;
  int         cmp_count = 0;
  logic [7:0] idx_l [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h2A, 8'h24, 8'h25};
  logic [7:0] rst_l [8] = '{8'hFB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0E, 8'h03};
  logic [2:0] mode_l [5] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1};
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
  // Pull-up: low while either party pulls
  assign sdio = !(mst_oe || sdio_oe);
  always #5 ref_clk = ~ref_clk;
  svtc_master i_mst (.bus_clk(bus_clk), .mst_oe(mst_oe), .sdio(sdio));
  svtc_top i_dut (.ref_clk(ref_clk), .rst(rst), .bus_clk(bus_clk), .sdio_in(sdio),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe), .strap_boot_hi(strap_boot_hi), .strap_addr(strap_addr),
    .dac_code(dac_code), .continuous_conduction(continuous_conduction),
    .auto_conduction(auto_conduction), .output_off_state(output_off_state),
    .vid_settled(vid_settled), .strap_done(strap_done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmd(input logic [4:0] c, input logic [7:0] i, input logic [7:0] d);
    i_mst.frame({4'h5, c, i, d}, found, rd);
  endtask : cmd
  task automatic rdreg(input logic [7:0] i, input logic [7:0] e);
    cmd(5'h05, i, 8'h00);
    `CHK({found, rd}, {1'b1, e})
  endtask : rdreg
  // Bounded wait for the code to land
  task automatic settle(input logic [7:0] e);
    for (int n = 0; n < 9000 && vid_settled !== 1'b1; n++) @(negedge ref_clk);
    `CHK(dac_code, e)
  endtask : settle
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // Watchdog, well beyond the expected run
  initial begin
    #900000;
    bad_count++;
    wrap_up();
  end
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    strap_boot_hi = 1'b0;
    strap_addr = 4'h5;
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int n = 0; n < 300 && strap_done !== 1'b1; n++) @(negedge ref_clk);
    settle(8'h83);
    `CHK(continuous_conduction, 1'b1)
    for (int k = 0; k < 8; k++) rdreg(idx_l[k], rst_l[k]);
    rdreg(8'h40, 8'hFF);
    cmd(5'h06, 8'h24, 8'h55);
    rdreg(8'h24, 8'h0E);
    cmd(5'h01, 8'h00, 8'h90);
    settle(8'h90);
    rdreg(8'h31, 8'h90);
    cmd(5'h06, 8'h33, 8'hFE);
    settle(8'h8E);
    cmd(5'h06, 8'h33, 8'h02);
    settle(8'h92);
    cmd(5'h06, 8'h33, 8'h00);
    cmd(5'h06, 8'h30, 8'hA0);
    cmd(5'h01, 8'h00, 8'hB0);
    rdreg(8'h31, 8'h90);
    settle(8'h90);
    cmd(5'h06, 8'h2A, 8'h01);
    rdreg(8'h25, 8'h07);
    cmd(5'h02, 8'h00, 8'h94);
    settle(8'h94);
    cmd(5'h03, 8'h00, 8'h80);
    `CHK(dac_code, 8'h80)
    `CHK(alert_n_oe, 1'b1)
    for (int p = 0; p < 5; p++) begin
      cmd(5'h04, 8'h00, 8'(p));
      rdreg(8'h32, 8'(p));
      `CHK({continuous_conduction, auto_conduction, output_off_state}, mode_l[p])
    end
    settle(8'h00);
    cmd(5'h04, 8'h00, 8'h05);
    rdreg(8'h32, 8'h04);
    cmd(5'h04, 8'h00, 8'h00);
    settle(8'h80);
    cmd(5'h1F, 8'h00, 8'h00);
    `CHK({found, alert_n_oe}, 2'b00)
    @(posedge ref_clk);
    #1 strap_addr = 4'h3;
    strap_boot_hi = 1'b1;
    rdreg(8'h31, 8'h80);
    i_mst.frame({4'h3, 5'h05, 8'h31, 8'h00}, found, rd);
    `CHK(found, 1'b0)
    wrap_up();
  end
endmodule : tb
`default_nettype wire
